//--- core/lbtd_pkg.sv
// What this block does
// - Carry test: status takes inverted carry, then carry is cleared.
// - Positive carry test: status takes carry, then carry is set.
// - Positive zero test: status takes zero flag, zero flag unchanged.
// - Indirect port test: port L[3:2]+4, bit L[1:0], status takes inverted pin.
// - Positive memory test: status takes page-zero nibble y bit b, not inverted.
// - Prefix 0x38 then 0110 k: OR immediate into memory at pointer pair.
// - Prefix 0x38 then 0010 k: OR accumulator with immediate.
// - Byte 010111bb tests accumulator bit b.
// - Byte 010110bb tests bit b of memory at pointer pair.
// - Prefix 0x39 then 10 b y: inverted page-zero memory bit test.
// - Prefix 0x3B then 10 b p: inverted port bit test.
// - Port tests read output latch for output-only ports, else pin level.
package lbtd_pkg;
  localparam logic [31:0] LBTD_REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] LBTD_REG_INSTR = 32'h0000_0004;
  localparam logic [31:0] LBTD_REG_STATE = 32'h0000_0008;
  localparam logic [31:0] LBTD_REG_PTR = 32'h0000_000C;
  localparam logic [31:0] LBTD_REG_PORTS = 32'h0000_0010;
  localparam logic [31:0] LBTD_REG_MEMACC = 32'h0000_0014;
  localparam logic [7:0] LBTD_OP_PFX_IMM = 8'h38;
  localparam logic [7:0] LBTD_OP_PFX_MEM = 8'h39;
  localparam logic [7:0] LBTD_OP_PFX_PORT = 8'h3B;
  localparam logic [7:0] LBTD_OP_OR_AM = 8'h1D;
  localparam logic [7:0] LBTD_OP_TEST_CF = 8'h06;
  localparam logic [7:0] LBTD_OP_TEST_POSITIVE_CF = 8'h04;
  localparam logic [7:0] LBTD_OP_TEST_POSITIVE_ZF = 8'h0E;
  localparam logic [7:0] LBTD_OP_TEST_POSITIVE_GF = 8'h01;
  localparam logic [7:0] LBTD_OP_TEST_L = 8'h37;
  localparam logic [5:0] LBTD_OP_TEST_A = 6'h17;
  localparam logic [5:0] LBTD_OP_TEST_HL = 6'h16;
  localparam logic [3:0] LBTD_SUB_OR_A = 4'h2;
  localparam logic [3:0] LBTD_SUB_OR_M = 4'h6;
  localparam logic [1:0] LBTD_SUB_TEST = 2'h2;
  localparam logic [1:0] LBTD_SUB_TEST_POSITIVE = 2'h3;
  localparam logic [3:0] LBTD_PORT_GRP_BASE = 4'h4;
  localparam logic [15:0] LBTD_OUT_ONLY_PORTS = 16'h0006;
  localparam logic [3:0] LBTD_RST_NIBBLE = 4'h0;
  localparam logic [1:0] LBTD_RESP_OKAY = 2'b00;
  localparam logic [1:0] LBTD_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {LBTD_IDLE, LBTD_READ, LBTD_WRITE} lbtd_state_t;
endpackage

//--- core/lbtd_port_sel.sv
`timescale 1ns/1ps
`default_nettype none
// Chooses one bit of one port; output-only ports answer from their latch.
module lbtd_port_sel
  import lbtd_pkg::*;
#(
  parameter int NPORTS = 16
) (
  // Port state
  input wire logic [4*NPORTS-1:0] pin_lvl,
  input wire logic [4*NPORTS-1:0] out_latch,
  // Selection
  input wire logic [3:0] port_idx,
  input wire logic [1:0] bit_idx,
  output logic bit_val
);
  logic [4*NPORTS-1:0] view;
  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : g_port
      assign view[4*g +: 4] = LBTD_OUT_ONLY_PORTS[g] ? out_latch[4*g +: 4]
                                                     : pin_lvl[4*g +: 4];
    end
  endgenerate
  assign bit_val = view[{port_idx, bit_idx}];
endmodule
`default_nettype wire

//--- core/lbtd_dmem.sv
`timescale 1ns/1ps
`default_nettype none
// Data memory with two combinational read ports and one clocked write port.
module lbtd_dmem
  import lbtd_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock only
  input wire logic aclk,
  // Ports
  input wire logic [AW-1:0] ra_addr,
  output logic [3:0] ra_data,
  input wire logic [AW-1:0] rb_addr,
  output logic [3:0] rb_data,
  input wire logic we,
  input wire logic [AW-1:0] wa_addr,
  input wire logic [3:0] wa_data
);
  logic [3:0] mem [0:(1<<AW)-1];
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[wa_addr] <= wa_data;
    end
  end
  assign ra_data = mem[ra_addr];
  assign rb_data = mem[rb_addr];
endmodule
`default_nettype wire

//--- core/lbtd_core.sv
`timescale 1ns/1ps
`default_nettype none
// Executes the OR and bit-test instructions written to the instruction register.
module lbtd_core
  import lbtd_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port pins of the sixteen ports
  input wire logic [63:0] port_pins,
  output logic [63:0] port_latch_q
);
  logic [3:0] accumulator_register_q;
  logic carry_flag_q;
  logic zero_flag_q;
  logic status_flag_q;
  logic general_flag_q;
  logic [3:0] high_pointer_q;
  logic [3:0] low_pointer_register_q;
  logic [7:0] prefix_q;
  logic prefix_pend_q;
  logic [63:0] pins_s1_q;
  logic [63:0] pins_s2_q;
  logic [AW-1:0] mem_addr_q;
  logic [3:0] mem_rdata;
  logic [3:0] mem_hl;
  logic [3:0] mem_y;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [3:0] mem_wd;
  logic [AW-1:0] hl_addr;
  logic [3:0] port_idx;
  logic [1:0] port_bit;
  logic port_bit_val;
  logic aw_hold_q;
  logic w_hold_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  logic exec;
  logic [7:0] ibyte;
  logic sw_mem_we;
  logic [31:0] rd_d;
  logic rd_ok;
  logic wr_ok;

  // Two-stage capture of the asynchronous port pins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_s1_q <= '0;
      pins_s2_q <= '0;
    end else begin
      pins_s1_q <= port_pins;
      pins_s2_q <= pins_s1_q;
    end
  end

  // The write fires once both address and data have been taken, in either order.
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_ok = awaddr_q[31:2] <= LBTD_REG_MEMACC[31:2];
  assign exec = wr_go && awaddr_q[31:2] == LBTD_REG_INSTR[31:2] && wstrb_q[0];
  assign ibyte = wdata_q[7:0];
  assign sw_mem_we = wr_go && awaddr_q[31:2] == LBTD_REG_MEMACC[31:2] && wstrb_q[0];
  assign hl_addr = AW'({high_pointer_q, low_pointer_register_q});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= LBTD_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? LBTD_RESP_OKAY : LBTD_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
      end
    end
  end

  // Prefix bytes are held until their second byte arrives.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prefix_q <= 8'h00;
      prefix_pend_q <= 1'b0;
    end else if (exec) begin
      if (!prefix_pend_q && (ibyte == LBTD_OP_PFX_IMM || ibyte == LBTD_OP_PFX_MEM ||
                             ibyte == LBTD_OP_PFX_PORT)) begin
        prefix_q <= ibyte;
        prefix_pend_q <= 1'b1;
      end else begin
        prefix_pend_q <= 1'b0;
      end
    end
  end

  assign port_idx = !prefix_pend_q ? low_pointer_register_q[3:2] + LBTD_PORT_GRP_BASE
                                   : ibyte[3:0];
  assign port_bit = !prefix_pend_q ? low_pointer_register_q[1:0] : ibyte[5:4];

  lbtd_port_sel #(.NPORTS(16)) u_port_sel (
    .pin_lvl(pins_s2_q),
    .out_latch(port_latch_q),
    .port_idx(port_idx),
    .bit_idx(port_bit),
    .bit_val(port_bit_val)
  );

  // Port B serves the page-zero operand while an instruction executes and the software
  // window otherwise, so a window read must not coincide with an executing write.
  lbtd_dmem #(.AW(AW)) u_dmem (
    .aclk(aclk),
    .ra_addr(hl_addr),
    .ra_data(mem_hl),
    .rb_addr(exec ? AW'(ibyte[3:0]) : mem_addr_q),
    .rb_data(mem_y),
    .we(mem_we),
    .wa_addr(mem_wa),
    .wa_data(mem_wd)
  );

  // Data memory write: the software memory window, else OR immediate into memory at the pointer pair.
  always_comb begin
    mem_we = 1'b0;
    mem_wa = hl_addr;
    mem_wd = mem_hl | ibyte[3:0];
    if (sw_mem_we) begin
      mem_we = 1'b1;
      mem_wa = AW'(wdata_q[AW+3:4]);
      mem_wd = wdata_q[3:0];
    end else if (exec && prefix_pend_q && prefix_q == LBTD_OP_PFX_IMM &&
                 ibyte[7:4] == LBTD_SUB_OR_M) begin
      mem_we = 1'b1;
    end
  end
  assign mem_rdata = mem_y;

  // Flags and accumulator; flags an instruction does not name are left alone.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accumulator_register_q <= LBTD_RST_NIBBLE;
      carry_flag_q <= 1'b0;
      zero_flag_q <= 1'b0;
      status_flag_q <= 1'b1;
      general_flag_q <= 1'b0;
    end else if (exec && prefix_pend_q) begin
      case (prefix_q)
        LBTD_OP_PFX_IMM: begin
          if (ibyte[7:4] == LBTD_SUB_OR_A) begin
            accumulator_register_q <= accumulator_register_q | ibyte[3:0];
            zero_flag_q <= (accumulator_register_q | ibyte[3:0]) == 4'h0;
          end else if (ibyte[7:4] == LBTD_SUB_OR_M) begin
            zero_flag_q <= (mem_hl | ibyte[3:0]) == 4'h0;
          end
        end
        LBTD_OP_PFX_MEM: begin
          if (ibyte[7:6] == LBTD_SUB_TEST) begin
            status_flag_q <= !mem_y[ibyte[5:4]];
          end else if (ibyte[7:6] == LBTD_SUB_TEST_POSITIVE) begin
            status_flag_q <= mem_y[ibyte[5:4]];
          end
        end
        LBTD_OP_PFX_PORT: begin
          if (ibyte[7:6] == LBTD_SUB_TEST) begin
            status_flag_q <= !port_bit_val;
          end else if (ibyte[7:6] == LBTD_SUB_TEST_POSITIVE) begin
            status_flag_q <= port_bit_val;
          end
        end
        default: begin
        end
      endcase
    end else if (exec && !prefix_pend_q) begin
      if (ibyte == LBTD_OP_TEST_CF) begin
        status_flag_q <= !carry_flag_q;
        carry_flag_q <= 1'b0;
      end else if (ibyte == LBTD_OP_TEST_POSITIVE_CF) begin
        status_flag_q <= carry_flag_q;
        carry_flag_q <= 1'b1;
      end else if (ibyte == LBTD_OP_TEST_POSITIVE_ZF) begin
        status_flag_q <= zero_flag_q;
      end else if (ibyte == LBTD_OP_TEST_POSITIVE_GF) begin
        status_flag_q <= general_flag_q;
      end else if (ibyte == LBTD_OP_TEST_L) begin
        status_flag_q <= !port_bit_val;
      end else if (ibyte[7:2] == LBTD_OP_TEST_A) begin
        status_flag_q <= !accumulator_register_q[ibyte[1:0]];
      end else if (ibyte[7:2] == LBTD_OP_TEST_HL) begin
        status_flag_q <= !mem_hl[ibyte[1:0]];
      end else if (ibyte == LBTD_OP_OR_AM) begin
        accumulator_register_q <= accumulator_register_q | mem_hl;
        zero_flag_q <= (accumulator_register_q | mem_hl) == 4'h0;
      end
    end else if (wr_go && awaddr_q[31:2] == LBTD_REG_STATE[31:2] && wstrb_q[0]) begin
      accumulator_register_q <= wdata_q[3:0];
      carry_flag_q <= wdata_q[4];
      zero_flag_q <= wdata_q[5];
      status_flag_q <= wdata_q[6];
      general_flag_q <= wdata_q[7];
    end
  end

  // Pointer pair, output latches and software memory address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_pointer_q <= LBTD_RST_NIBBLE;
      low_pointer_register_q <= LBTD_RST_NIBBLE;
      port_latch_q <= '0;
      mem_addr_q <= '0;
    end else if (wr_go && wstrb_q[0]) begin
      if (awaddr_q[31:2] == LBTD_REG_PTR[31:2]) begin
        low_pointer_register_q <= wdata_q[3:0];
        high_pointer_q <= wdata_q[7:4];
      end
      if (awaddr_q[31:2] == LBTD_REG_PORTS[31:2]) begin
        port_latch_q[{wdata_q[11:8], 2'b00} +: 4] <= wdata_q[3:0];
      end
      if (awaddr_q[31:2] == LBTD_REG_CTRL[31:2]) begin
        mem_addr_q <= AW'(wdata_q[AW-1:0]);
      end
    end
  end

  // Read path.
  always_comb begin
    rd_d = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr[31:2])
      LBTD_REG_CTRL[31:2]: rd_d = 32'(mem_addr_q);
      LBTD_REG_INSTR[31:2]: rd_d = {23'h0, prefix_pend_q, prefix_q};
      LBTD_REG_STATE[31:2]: rd_d = {24'h0, general_flag_q, status_flag_q, zero_flag_q,
                                    carry_flag_q, accumulator_register_q};
      LBTD_REG_PTR[31:2]: rd_d = {24'h0, high_pointer_q, low_pointer_register_q};
      LBTD_REG_PORTS[31:2]: rd_d = pins_s2_q[31:0];
      LBTD_REG_MEMACC[31:2]: rd_d = {28'h0, mem_rdata};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= LBTD_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rd_ok ? LBTD_RESP_OKAY : LBTD_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/lbtd_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lbtd_core_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read side
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Ports
  input wire logic [63:0] port_latch_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_AWREADY_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held two cycles");
  AST_ARREADY_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready held two cycles");
  AST_BVALID_LATENCY: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_RVALID_LATENCY: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data late");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_BVALID_CAUSE: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready || s_axi_wready, 2))
    else $error("response without write");
  AST_RVALID_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  AST_LATCH_ON_WRITE: assert property (!$stable(port_latch_q) |-> $rose(s_axi_bvalid))
    else $error("port latch moved without write");
endmodule
bind lbtd_core lbtd_core_checker u_checker (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .port_latch_q(port_latch_q)
);
`default_nettype wire

//--- tb/lbtd_prog_rom.sv
`timescale 1ns/1ps
`default_nettype none
// Program store handing the bench its one-byte and prefix opcodes.
module lbtd_prog_rom
  import lbtd_pkg::*;
(
  // Fetch
  input wire logic [2:0] pc,
  output logic [7:0] op
);
  always_comb begin
    case (pc)
      3'h0: op = 8'h06;
      3'h1: op = 8'h04;
      3'h2: op = 8'h0E;
      3'h3: op = 8'h37;
      3'h4: op = 8'h38;
      3'h5: op = 8'h39;
      3'h6: op = 8'h3B;
      default: op = 8'h01;
    endcase
  end
endmodule
`default_nettype wire

//--- tb/lbtd_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lbtd_core_tb_top
  import lbtd_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs_q;
  logic [63:0] port_pins, port_latch_q;
  logic [2:0] pc;
  logic [7:0] op;
  logic [1:0] bb;
  logic [3:0] nib;
  int fail_count, checked;
  int cyc = 0;
  lbtd_core #(.AW(8)) DUT (.*);
  lbtd_prog_rom u_rom (.pc(pc), .op(op));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Cut a hang short; the whole run needs well under a thousand cycles.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rs_q = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_q = s_axi_rdata;
    rs_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task ex(input logic [7:0] b);
    wr(LBTD_REG_INSTR, {24'h0, b});
  endtask
  task fetch(input logic [2:0] i);
    pc <= i;
    @(posedge aclk);
    ex(op);
  endtask
  task setst(input logic [7:0] s);
    wr(LBTD_REG_STATE, {24'h0, s});
  endtask
  task getst(input string n, input logic [7:0] e);
    rd(LBTD_REG_STATE);
    chk(n, rd_q[7:0], e);
  endtask
  task setmem(input logic [7:0] a, input logic [3:0] d);
    wr(LBTD_REG_MEMACC, {20'h0, a, d});
  endtask
  task t_flags;
    setst(8'h95);
    fetch(3'h0); getst("carry1", 8'h85);
    fetch(3'h0); getst("carry0", 8'hC5);
    fetch(3'h1); getst("pcarry0", 8'h95);
    fetch(3'h1); getst("pcarry1", 8'hD5);
    setst(8'h2A);
    fetch(3'h2); getst("pzero1", 8'h6A);
    setst(8'h4A);
    fetch(3'h2); getst("pzero0", 8'h0A);
    setst(8'h80);
    fetch(3'h7); getst("pgen1", 8'hC0);
  endtask
  task t_port_l;
    port_pins <= 64'h0000_0000_0040_0000;
    setst(8'h00);
    wr(LBTD_REG_PTR, 32'h0000_0006);
    fetch(3'h3); getst("indirect_hi", 8'h00);
    wr(LBTD_REG_PTR, 32'h0000_0007);
    fetch(3'h3); getst("indirect_lo", 8'h40);
  endtask
  task t_or;
    wr(LBTD_REG_PTR, 32'h0000_00A5);
    setmem(8'hA5, 4'h9);
    setst(8'h90);
    fetch(3'h4); ex(8'h64);
    wr(LBTD_REG_CTRL, 32'h0000_00A5);
    rd(LBTD_REG_MEMACC);
    chk("or_mem", rd_q[3:0], 4'hD);
    getst("or_mem_flags", 8'h90);
    fetch(3'h4); ex(8'h23); getst("or_acc", 8'h93);
    ex(LBTD_OP_OR_AM); getst("or_acc_mem", 8'h9F);
  endtask
  task t_bits;
    setmem(8'h0F, 4'hA);
    for (int b = 0; b < 4; b++) begin
      bb = b[1:0];
      setst(8'h05);
      ex({6'h17, bb}); getst("test_acc", {1'b0, bb[0], 6'h05});
      nib = 4'hD;
      ex({6'h16, bb}); getst("test_ptr", {1'b0, ~nib[bb], 6'h05});
      nib = 4'hA;
      fetch(3'h5); ex({2'b11, bb, 4'hF});
      getst("ptest_y", {1'b0, nib[bb], 6'h05});
      fetch(3'h5); ex({2'b10, bb, 4'hF});
      getst("test_y", {1'b0, ~nib[bb], 6'h05});
    end
  endtask
  task t_port;
    wr(LBTD_REG_PORTS, 32'h0000_010B);
    chk("latch", port_latch_q[7:4], 4'hB);
    setst(8'h00);
    fetch(3'h6); ex(8'hB1); getst("out_port", 8'h00);
    fetch(3'h6); ex(8'h84); getst("in_port", 8'h40);
    fetch(3'h6); ex(8'hC4); getst("in_port_pos", 8'h00);
    rd(32'h0000_0040);
    chk("bad_rresp", rs_q, LBTD_RESP_SLVERR);
    wr(32'h0000_0040, 32'h0);
    chk("bad_bresp", rs_q, LBTD_RESP_SLVERR);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    port_pins = 64'h0;
    pc = 3'h0;
    fail_count = 0;
    checked = 0;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_flags();
    t_port_l();
    t_or();
    t_bits();
    t_port();
    wrap_up();
  end
endmodule
`default_nettype wire
